// >>> design/analog_output_scaler.sv
// Analogue output scaler: source pick, linear scaling, clamping and fault override.
`include "analog_output_scaler_cfg.svh"

module analog_output_scaler #(
   parameter int VAL_W      = 32,
   parameter int SEC_CYCLES = `AOS_SEC_CYCLES
) (
   input  wire logic                    CLK,
   input  wire logic                    SYS_RST,
   input  wire logic                    CE,
   input  wire logic [1:0]              OUTPUT_KIND,
   input  wire logic [2:0]              OUTPUT_MODE_SELECT,
   input  wire logic [1:0]              SOURCE_SELECT,
   input  wire logic                    OUTPUT_HOLD_SELECT,
   input  wire logic signed [VAL_W-1:0] FLOW_VALUE,
   input  wire logic signed [VAL_W-1:0] BATCH_VALUE,
   input  wire logic signed [VAL_W-1:0] TOTAL_VALUE,
   input  wire logic signed [VAL_W-1:0] PEAK_VALUE,
   input  wire logic                    BATCH_KILO_UNITS,
   input  wire logic                    TOTAL_KILO_UNITS,
   input  wire logic                    BATCH_ENABLED,
   input  wire logic signed [VAL_W-1:0] SCALE_LOW_POINT,
   input  wire logic signed [VAL_W-1:0] SCALE_HIGH_POINT,
   input  wire logic [9:0]              LOW_EXTENSION_PCT,
   input  wire logic [9:0]              HIGH_EXTENSION_PCT,
   input  wire logic [2:0]              FAULT_OUTPUT_LEVEL,
   input  wire logic                    RANGE_EXCEEDED,
   input  wire logic                    FRAME_RECEIVED,
   input  wire logic [16:0]             BUS_LEVEL,
   input  wire logic [6:0]              FRAME_GAP_TIMEOUT,
   output logic [16:0]                  OUT_LEVEL,
   output logic                         OUT_ENABLE,
   output logic                         OUT_CRITICAL,
   output logic                         OUT_CLAMPED,
   output logic                         OUT_GAP_EXPIRED
);
   localparam int PW = VAL_W + 12;
   localparam int DW = PW + 2;
   localparam int NW = DW + 16;
   localparam int SW = $clog2(SEC_CYCLES + 1);
   localparam logic signed [PW-1:0] KILO = PW'(`AOS_KILO);

   ////////////////////////////////////////////////////////////////////////////
   // Mode decode and range limits.

   analog_output_scaler_pkg::mode_t  mode;
   analog_output_scaler_pkg::kind_t  kind;
   analog_output_scaler_pkg::src_t   src;
   analog_output_scaler_pkg::fault_t fsel;
   analog_output_scaler_pkg::state_t state;

   logic [16:0] range_lo;
   logic [16:0] range_hi;
   logic        mode_ok;
   logic        bus_mode;
   logic        output_on;

   assign mode = analog_output_scaler_pkg::mode_t'(OUTPUT_MODE_SELECT);
   assign kind = analog_output_scaler_pkg::kind_t'(OUTPUT_KIND);
   assign src  = analog_output_scaler_pkg::src_t'(SOURCE_SELECT);
   assign fsel = analog_output_scaler_pkg::fault_t'(FAULT_OUTPUT_LEVEL);

   always_comb begin
      range_lo = `AOS_LVL_0;
      range_hi = `AOS_LVL_0;
      mode_ok  = 1'b0;
      bus_mode = 1'b0;
      case (mode)
         analog_output_scaler_pkg::MODE_OFF: begin
            mode_ok = (kind != analog_output_scaler_pkg::KIND_NONE);
         end
         analog_output_scaler_pkg::MODE_C0_20: begin
            mode_ok  = (kind == analog_output_scaler_pkg::KIND_ACT_CUR);
            range_hi = `AOS_LVL_20MA;
         end
         analog_output_scaler_pkg::MODE_C4_20: begin
            mode_ok  = (kind == analog_output_scaler_pkg::KIND_ACT_CUR) ||
                       (kind == analog_output_scaler_pkg::KIND_PAS_CUR);
            range_lo = `AOS_LVL_4MA;
            range_hi = `AOS_LVL_20MA;
         end
         analog_output_scaler_pkg::MODE_V0_5: begin
            mode_ok  = (kind == analog_output_scaler_pkg::KIND_VOLT);
            range_hi = `AOS_LVL_5V;
         end
         analog_output_scaler_pkg::MODE_V1_5: begin
            mode_ok  = (kind == analog_output_scaler_pkg::KIND_VOLT);
            range_lo = `AOS_LVL_1V;
            range_hi = `AOS_LVL_5V;
         end
         analog_output_scaler_pkg::MODE_V0_10: begin
            mode_ok  = (kind == analog_output_scaler_pkg::KIND_VOLT);
            range_hi = `AOS_LVL_10V;
         end
         analog_output_scaler_pkg::MODE_V2_10: begin
            mode_ok  = (kind == analog_output_scaler_pkg::KIND_VOLT);
            range_lo = `AOS_LVL_2V;
            range_hi = `AOS_LVL_10V;
         end
         analog_output_scaler_pkg::MODE_BUS: begin
            mode_ok  = (kind != analog_output_scaler_pkg::KIND_NONE);
            bus_mode = mode_ok;
         end
         default: begin
            mode_ok = 1'b0;
         end
      endcase
   end

   // A mode that this output kind does not offer behaves as off.
   assign output_on = mode_ok && (mode != analog_output_scaler_pkg::MODE_OFF);

   ////////////////////////////////////////////////////////////////////////////
   // Extended range borders.

   logic [9:0]  lo_max;
   logic [9:0]  hi_max;
   logic [9:0]  lo_pct;
   logic [9:0]  hi_pct;
   logic [31:0] lo_ext;
   logic [31:0] hi_ext;
   logic [16:0] lo_border;
   logic [17:0] hi_border;

   assign lo_max = (kind == analog_output_scaler_pkg::KIND_PAS_CUR) ?
                   `AOS_LO_MAX_PAS : `AOS_LO_MAX_ACT;
   assign hi_max = (kind == analog_output_scaler_pkg::KIND_VOLT) ?
                   `AOS_HI_MAX_VOL : `AOS_HI_MAX_CUR;
   assign lo_pct = (LOW_EXTENSION_PCT > lo_max) ? lo_max : LOW_EXTENSION_PCT;
   assign hi_pct = (HIGH_EXTENSION_PCT > hi_max) ? hi_max : HIGH_EXTENSION_PCT;

   assign lo_ext = (32'(range_lo) * 32'(lo_pct)) / 32'(`AOS_PCT_FULL);
   assign hi_ext = (32'(range_hi) * 32'(hi_pct)) / 32'(`AOS_PCT_FULL);
   assign lo_border = range_lo - 17'(lo_ext);
   assign hi_border = 18'(range_hi) + 18'(hi_ext);

   ////////////////////////////////////////////////////////////////////////////
   // Source selection and scale points.

   logic signed [VAL_W-1:0] live_val;
   logic signed [VAL_W-1:0] src_val;
   logic                    kilo;
   logic                    batch_fault;
   logic signed [PW-1:0]    lo_pt;
   logic signed [PW-1:0]    hi_pt;
   logic signed [NW-1:0]    diff;
   logic signed [NW-1:0]    span;

   always_comb begin
      case (src)
         analog_output_scaler_pkg::SRC_BATCH: begin
            live_val = BATCH_VALUE;
            kilo     = BATCH_KILO_UNITS;
         end
         analog_output_scaler_pkg::SRC_TOTAL: begin
            live_val = TOTAL_VALUE;
            kilo     = TOTAL_KILO_UNITS;
         end
         default: begin
            live_val = FLOW_VALUE;
            kilo     = 1'b0;
         end
      endcase
   end

   assign src_val = OUTPUT_HOLD_SELECT ? PEAK_VALUE : live_val;
   assign batch_fault = (src == analog_output_scaler_pkg::SRC_BATCH) && !BATCH_ENABLED;

   assign lo_pt = kilo ? PW'(PW'(SCALE_LOW_POINT) * KILO) : PW'(SCALE_LOW_POINT);
   assign hi_pt = kilo ? PW'(PW'(SCALE_HIGH_POINT) * KILO) : PW'(SCALE_HIGH_POINT);

   // Signed differences keep a falling characteristic when the low point is higher.
   assign diff = NW'(src_val) - NW'(lo_pt);
   assign span = NW'($signed({1'b0, range_hi})) - NW'($signed({1'b0, range_lo}));

   ////////////////////////////////////////////////////////////////////////////
   // Division sequence.

   aos_div_if #(.NW(NW), .DW(DW)) div_bus ();

   logic                 start;
   logic signed [NW-1:0] numer;
   logic signed [DW-1:0] denom;

   assign div_bus.ce    = CE;
   assign div_bus.start = start;
   assign div_bus.numer = numer;
   assign div_bus.denom = denom;

   aos_divider #(
      .NW (NW),
      .DW (DW)
   ) u_div (
      .clk (CLK),
      .rst (SYS_RST),
      .dv  (div_bus)
   );

   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         state <= analog_output_scaler_pkg::ST_IDLE;
         start <= 1'b0;
         numer <= '0;
         denom <= '0;
      end else if (CE) begin
         case (state)
            analog_output_scaler_pkg::ST_IDLE: begin
               if (output_on && !bus_mode) begin
                  numer <= NW'(diff * span);
                  denom <= DW'(hi_pt) - DW'(lo_pt);
                  start <= 1'b1;
                  state <= analog_output_scaler_pkg::ST_WAIT;
               end
            end
            analog_output_scaler_pkg::ST_WAIT: begin
               start <= 1'b0;
               if (div_bus.done) begin
                  state <= analog_output_scaler_pkg::ST_IDLE;
               end
            end
            default: begin
               start <= 1'b0;
               state <= analog_output_scaler_pkg::ST_IDLE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Offset and clamp of the quotient.

   logic signed [NW:0] raw;
   logic [16:0]        next_scaled;
   logic               next_clamped;
   logic [16:0]        scaled;
   logic               clamped;

   assign raw = (NW+1)'(div_bus.quot) + (NW+1)'($signed({1'b0, range_lo}));

   always_comb begin
      next_scaled  = 17'(raw);
      next_clamped = 1'b0;
      if (raw < (NW+1)'($signed({1'b0, lo_border}))) begin
         next_scaled  = lo_border;
         next_clamped = 1'b1;
      end else if (raw > (NW+1)'($signed({1'b0, hi_border}))) begin
         next_scaled  = 17'(hi_border);
         next_clamped = 1'b1;
      end
   end

   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         scaled  <= `AOS_LVL_0;
         clamped <= 1'b0;
      end else if (CE && div_bus.done) begin
         scaled  <= next_scaled;
         clamped <= next_clamped;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Frame gap supervision in bus mode.

   logic [SW-1:0] sub_cnt;
   logic [6:0]    sec_cnt;
   logic [6:0]    timeout;
   logic          gap_expired;

   assign timeout = (FRAME_GAP_TIMEOUT > `AOS_TIMEOUT_MAX) ?
                    `AOS_TIMEOUT_MAX : FRAME_GAP_TIMEOUT;

   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         sub_cnt <= '0;
         sec_cnt <= '0;
      end else if (CE) begin
         if (!bus_mode || FRAME_RECEIVED) begin
            sub_cnt <= '0;
            sec_cnt <= '0;
         end else if (sub_cnt == SW'(SEC_CYCLES - 1)) begin
            sub_cnt <= '0;
            if (sec_cnt != 7'h7F) begin
               sec_cnt <= sec_cnt + 7'h01;
            end
         end else begin
            sub_cnt <= sub_cnt + SW'(1);
         end
      end
   end

   // Counted seconds only ever reach the timeout after a whole gap has elapsed.
   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         gap_expired <= 1'b0;
      end else if (CE) begin
         gap_expired <= bus_mode && !FRAME_RECEIVED && (timeout != 7'h00) &&
                        (sec_cnt >= timeout);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Fault level and output register.

   logic        critical;
   logic        fault_keep;
   logic [16:0] fault_val;

   assign critical = bus_mode ? gap_expired
                              : (RANGE_EXCEEDED || batch_fault);

   always_comb begin
      fault_keep = 1'b0;
      fault_val  = `AOS_LVL_0;
      if (kind == analog_output_scaler_pkg::KIND_VOLT) begin
         case (fsel)
            analog_output_scaler_pkg::FLT_LEVEL1: fault_val = `AOS_FLT_11V;
            analog_output_scaler_pkg::FLT_LEVEL2: fault_val = `AOS_FLT_5_5V;
            analog_output_scaler_pkg::FLT_LEVEL3: fault_val = `AOS_FLT_1_2V;
            analog_output_scaler_pkg::FLT_LEVEL4: fault_val = `AOS_FLT_0_6V;
            analog_output_scaler_pkg::FLT_LEVEL5: fault_val = `AOS_LVL_0;
            default: fault_keep = 1'b1;
         endcase
      end else begin
         case (fsel)
            analog_output_scaler_pkg::FLT_LEVEL1: fault_val = `AOS_FLT_22_1MA;
            analog_output_scaler_pkg::FLT_LEVEL2: fault_val = `AOS_FLT_3_4MA;
            analog_output_scaler_pkg::FLT_LEVEL3: begin
               fault_keep = (kind != analog_output_scaler_pkg::KIND_ACT_CUR);
            end
            default: fault_keep = 1'b1;
         endcase
      end
   end

   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         OUT_LEVEL  <= `AOS_LVL_0;
         OUT_ENABLE <= 1'b0;
      end else if (CE) begin
         OUT_ENABLE <= output_on;
         if (!output_on) begin
            OUT_LEVEL <= `AOS_LVL_0;
         end else if (critical) begin
            if (!fault_keep) begin
               OUT_LEVEL <= fault_val;
            end
         end else begin
            OUT_LEVEL <= bus_mode ? BUS_LEVEL : scaled;
         end
      end
   end

   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         OUT_CRITICAL    <= 1'b0;
         OUT_CLAMPED     <= 1'b0;
         OUT_GAP_EXPIRED <= 1'b0;
      end else if (CE) begin
         OUT_CRITICAL    <= output_on && critical;
         OUT_CLAMPED     <= output_on && !bus_mode && clamped;
         OUT_GAP_EXPIRED <= gap_expired;
      end
   end
endmodule : analog_output_scaler

// >>> pkg/analog_output_scaler_cfg.svh
// Constants of the analogue output scaler: levels, limits and timing counts.
// Summary of operation
// - Active current output offers off, 0-20 mA, 4-20 mA and bus-written level.
// - Passive current output offers only off, 4-20 mA and bus-written level.
// - Voltage output offers off, 0-5, 1-5, 0-10, 2-10 V and bus-written level.
// - Source select picks flow rate, batch counter or total counter as input.
// - Batch source with batching disabled drives the output to its fault level.
// - Output is lower limit plus normalised source position times range span.
// - Low scale point above high scale point gives a falling characteristic.
// - Counter scale points are plain units or thousands per source unit select.
// - Results outside the extended range clamp to its nearest border, 0.1 % steps.
// - Lower border is lower limit less its percentage, up to 99.9 or 29.9.
// - Upper border is upper limit plus its percentage, up to 19.9 or 9.9.
// - Current fault holds or goes 22.1 or 3.4 mA; 0 mA only when active.
// - Voltage fault holds or goes to 11, 5.5, 1.2, 0.6 or 0 V.
// - After the critical condition ends the scaled and clamped value returns.
// - Outside bus mode an exceeded measurement range or a disabled batch source is the critical condition.
// - In bus mode a frame gap longer than the timeout forces the fault state.
// - Frame gap timeout is 0 to 99 seconds; zero disables supervision.
// - Hold select feeds either the live value or the held peak value.
`ifndef ANALOG_OUTPUT_SCALER_CFG_SVH
`define ANALOG_OUTPUT_SCALER_CFG_SVH

// Output levels in microamps for current and millivolts for voltage.
`define AOS_LVL_0       17'h00000
`define AOS_LVL_4MA     17'h00FA0
`define AOS_LVL_20MA    17'h04E20
`define AOS_LVL_1V      17'h003E8
`define AOS_LVL_2V      17'h007D0
`define AOS_LVL_5V      17'h01388
`define AOS_LVL_10V     17'h02710
`define AOS_FLT_22_1MA  17'h05654
`define AOS_FLT_3_4MA   17'h00D48
`define AOS_FLT_11V     17'h02AF8
`define AOS_FLT_5_5V    17'h0157C
`define AOS_FLT_1_2V    17'h004B0
`define AOS_FLT_0_6V    17'h00258

// Extension percentages in tenths of a percent.
`define AOS_PCT_FULL    10'h3E8
`define AOS_LO_MAX_ACT  10'h3E7
`define AOS_LO_MAX_PAS  10'h12B
`define AOS_HI_MAX_CUR  10'h0C7
`define AOS_HI_MAX_VOL  10'h063

// Counter units and frame gap supervision.
`define AOS_KILO        32'h000003E8
`define AOS_TIMEOUT_MAX 7'h63
`define AOS_SECOND_NS   1000000000
`define AOS_CLK_NS      20
`define AOS_SEC_CYCLES  (`AOS_SECOND_NS / `AOS_CLK_NS)

`endif

// >>> pkg/analog_output_scaler_pkg.sv
// Types shared by the analogue output scaler modules.
package analog_output_scaler_pkg;
   typedef enum logic [2:0] {
      MODE_OFF, MODE_C0_20, MODE_C4_20, MODE_V0_5,
      MODE_V1_5, MODE_V0_10, MODE_V2_10, MODE_BUS
   } mode_t;
   typedef enum logic [1:0] {KIND_ACT_CUR, KIND_PAS_CUR, KIND_VOLT, KIND_NONE} kind_t;
   typedef enum logic [1:0] {SRC_FLOW, SRC_BATCH, SRC_TOTAL, SRC_RSVD} src_t;
   typedef enum logic [2:0] {
      FLT_KEEP_LAST_VALUE, FLT_LEVEL1, FLT_LEVEL2, FLT_LEVEL3, FLT_LEVEL4, FLT_LEVEL5,
      FLT_RSVD6, FLT_RSVD7
   } fault_t;
   typedef enum logic {ST_IDLE, ST_WAIT} state_t;
endpackage : analog_output_scaler_pkg

// >>> pkg/aos_div_if.sv
// Request and answer signals between the scaler and its divider.
interface aos_div_if #(
   parameter int NW = 62,
   parameter int DW = 46
);
   logic                 ce;
   logic                 start;
   logic signed [NW-1:0] numer;
   logic signed [DW-1:0] denom;
   logic                 done;
   logic signed [NW-1:0] quot;
   modport requester (output ce, output start, output numer, output denom,
                      input done, input quot);
   modport divider (input ce, input start, input numer, input denom,
                    output done, output quot);
endinterface : aos_div_if

// >>> design/aos_divider.sv
// Sequential signed divider, one quotient bit per enabled cycle.
module aos_divider #(
   parameter int NW = 62,
   parameter int DW = 46
) (
   input wire logic clk,
   input wire logic rst,
   aos_div_if.divider dv
);
   logic [NW-1:0] quo;
   logic [DW:0]   rem;
   logic [DW-1:0] dmag;
   logic          neg;
   logic          zero;
   logic          busy;
   logic [6:0]    cnt;
   logic [DW:0]   shifted;

   assign shifted = {rem[DW-1:0], quo[NW-1]};

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         quo  <= '0;
         rem  <= '0;
         dmag <= '0;
         neg  <= 1'b0;
         zero <= 1'b0;
         busy <= 1'b0;
         cnt  <= '0;
      end else if (dv.ce) begin
         if (dv.start && !busy) begin
            quo  <= dv.numer[NW-1] ? NW'(-dv.numer) : dv.numer;
            dmag <= dv.denom[DW-1] ? DW'(-dv.denom) : dv.denom;
            neg  <= dv.numer[NW-1] ^ dv.denom[DW-1];
            zero <= (dv.denom == '0);
            rem  <= '0;
            cnt  <= 7'(NW);
            busy <= 1'b1;
         end else if (busy) begin
            if (shifted >= {1'b0, dmag}) begin
               rem <= shifted - {1'b0, dmag};
               quo <= {quo[NW-2:0], 1'b1};
            end else begin
               rem <= shifted;
               quo <= {quo[NW-2:0], 1'b0};
            end
            cnt <= cnt - 7'h01;
            if (cnt == 7'h01) begin
               busy <= 1'b0;
            end
         end
      end
   end

   // Answer pulse and signed result, zero for a zero divisor.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         dv.done <= 1'b0;
         dv.quot <= '0;
      end else if (dv.ce) begin
         dv.done <= busy && (cnt == 7'h01);
         if (busy && (cnt == 7'h01)) begin
            if (zero) begin
               dv.quot <= '0;
            end else begin
               dv.quot <= neg ? NW'(-{quo[NW-2:0], shifted >= {1'b0, dmag}})
                              : {quo[NW-2:0], shifted >= {1'b0, dmag}};
            end
         end
      end
   end
endmodule : aos_divider

// >>> dv/aos_loop_receiver.sv
// Loop receiver model that senses the level only while the output drives it.
module aos_loop_receiver (
   input wire logic [16:0] level,
   input wire logic        enable,
   output logic [16:0]     sensed
);
   timeunit 1ns;
   timeprecision 1ps;
   assign sensed = enable ? level : 17'h00000;
endmodule : aos_loop_receiver

// >>> dv/analog_output_scaler_monitor.sv
// Port checker of the analogue output scaler, bound to its top module.
module analog_output_scaler_monitor #(
   parameter int SEC_CYCLES = 20
) (
   input wire logic        CLK,
   input wire logic        SYS_RST,
   input wire logic        CE,
   input wire logic [1:0]  OUTPUT_KIND,
   input wire logic [2:0]  OUTPUT_MODE_SELECT,
   input wire logic [1:0]  SOURCE_SELECT,
   input wire logic        BATCH_ENABLED,
   input wire logic [2:0]  FAULT_OUTPUT_LEVEL,
   input wire logic        RANGE_EXCEEDED,
   input wire logic        FRAME_RECEIVED,
   input wire logic [6:0]  FRAME_GAP_TIMEOUT,
   input wire logic [16:0] OUT_LEVEL,
   input wire logic        OUT_ENABLE,
   input wire logic        OUT_CRITICAL,
   input wire logic        OUT_GAP_EXPIRED
);
   timeunit 1ns;
   timeprecision 1ps;
   logic   cur_on;
   longint gap;
   default clocking @(posedge CLK);
   endclocking
   default disable iff (SYS_RST || !CE);
   assign cur_on = OUTPUT_KIND == 2'h0 && OUTPUT_MODE_SELECT inside {3'h1, 3'h2};
   // Cycles since the last frame, to bound when the gap flag may rise.
   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         gap <= 0;
      end else if (FRAME_RECEIVED) begin
         gap <= 0;
      end else if (gap < longint'(SEC_CYCLES) * 100) begin
         gap <= gap + 1;
      end
   end
   ////////////////////////////////////////
   AST_RANGE_CRIT: assert property (cur_on && RANGE_EXCEEDED |=> OUT_CRITICAL)
      else $error("range excess not critical");
   AST_BATCH_OFF: assert property (cur_on && SOURCE_SELECT == 2'h1
      && !BATCH_ENABLED |=> OUT_CRITICAL)
      else $error("disabled batch not critical");
   AST_ACT_HIGH: assert property (OUT_CRITICAL && OUT_ENABLE
      && $past(OUTPUT_KIND) == 2'h0 && $past(FAULT_OUTPUT_LEVEL) == 3'h1
      |-> OUT_LEVEL == 17'h05654)
      else $error("wrong high fault current");
   AST_PAS_LOW: assert property (OUT_CRITICAL && OUT_ENABLE && $past(OUTPUT_KIND) == 2'h1
      && $past(FAULT_OUTPUT_LEVEL) == 3'h2 |-> OUT_LEVEL == 17'h00D48)
      else $error("wrong low fault current");
   AST_VOLT_LOW: assert property (OUT_CRITICAL && OUT_ENABLE
      && $past(OUTPUT_KIND) == 2'h2 && $past(FAULT_OUTPUT_LEVEL) == 3'h4
      |-> OUT_LEVEL == 17'h00258)
      else $error("wrong fault voltage");
   AST_FRAME_CLR: assert property (FRAME_RECEIVED |-> ##2 !OUT_GAP_EXPIRED)
      else $error("frame did not clear gap flag");
   AST_GAP_LATE: assert property ($rose(OUT_GAP_EXPIRED) |-> gap > longint'(SEC_CYCLES)
      * (FRAME_GAP_TIMEOUT > 7'h63 ? 7'h63 : FRAME_GAP_TIMEOUT))
      else $error("gap flag too early");
   AST_OFF_IDLE: assert property (OUTPUT_MODE_SELECT == 3'h0
      ##1 OUTPUT_MODE_SELECT == 3'h0 |-> !OUT_ENABLE && OUT_LEVEL == 17'h00000)
      else $error("output active while off");
   AST_PAS_NO020: assert property (OUTPUT_KIND == 2'h1 && OUTPUT_MODE_SELECT == 3'h1
      |=> !OUT_ENABLE)
      else $error("passive 0-20 mode enabled");
endmodule : analog_output_scaler_monitor

bind analog_output_scaler analog_output_scaler_monitor #(.SEC_CYCLES(SEC_CYCLES)) mon_u (
   .CLK(CLK), .SYS_RST(SYS_RST), .CE(CE), .OUTPUT_KIND(OUTPUT_KIND),
   .OUTPUT_MODE_SELECT(OUTPUT_MODE_SELECT), .SOURCE_SELECT(SOURCE_SELECT),
   .BATCH_ENABLED(BATCH_ENABLED), .FAULT_OUTPUT_LEVEL(FAULT_OUTPUT_LEVEL),
   .RANGE_EXCEEDED(RANGE_EXCEEDED), .FRAME_RECEIVED(FRAME_RECEIVED),
   .FRAME_GAP_TIMEOUT(FRAME_GAP_TIMEOUT), .OUT_LEVEL(OUT_LEVEL), .OUT_ENABLE(OUT_ENABLE),
   .OUT_CRITICAL(OUT_CRITICAL), .OUT_GAP_EXPIRED(OUT_GAP_EXPIRED));

// >>> dv/test_analog_output_scaler.sv
// Self-checking bench of the analogue output scaler with a loop receiver.
module test_analog_output_scaler;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int SEC = 20;
   logic clk = 1'b0, rst = 1'b1, hold = 1'b0, bken = 1'b1, bkilo = 1'b0, tkilo = 1'b0;
   logic rexc = 1'b0, frame = 1'b0, ce = 1'b1, en, crit, clamped, expired;
   logic [1:0] kind = 2'h0, src = 2'h0;
   logic [2:0] mode = 3'h0, flt = 3'h1;
   logic signed [31:0] flow = 32'h1F4, batch = 32'h0, total = 32'h0, peak = 32'h0;
   logic signed [31:0] lo = 32'h0, hi = 32'h3E8;
   logic [9:0] lpct = 10'h0, hpct = 10'h0;
   logic [6:0] gto = 7'h0;
   logic [16:0] blvl = 17'h01234, level, sensed;
   int mismatches, n_compared;
   logic [1:0] kt1[10] = '{2'h0, 2'h0, 2'h2, 2'h2, 2'h2, 2'h2, 2'h1, 2'h1, 2'h3, 2'h0};
   logic [2:0] mt1[10] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h1, 3'h2, 3'h2, 3'h0};
   logic [16:0] et1[10] = '{17'h2710, 17'h2EE0, 17'h9C4, 17'hBB8, 17'h1388, 17'h1770,
      17'h0, 17'h2EE0, 17'h0, 17'h0};
   logic [1:0] kt2[12] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2};
   logic [2:0] ft2[12] = '{3'h1, 3'h2, 3'h3, 3'h0, 3'h2, 3'h3, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h0};
   logic [16:0] et2[12] = '{17'h5654, 17'hD48, 17'h0, 17'h2EE0, 17'hD48, 17'h2EE0, 17'h2AF8,
      17'h157C, 17'h4B0, 17'h258, 17'h0, 17'h9C4};
   analog_output_scaler #(.SEC_CYCLES(SEC)) dut_u (
      .CLK(clk), .SYS_RST(rst), .CE(ce), .OUTPUT_KIND(kind), .OUTPUT_MODE_SELECT(mode),
      .SOURCE_SELECT(src), .OUTPUT_HOLD_SELECT(hold), .FLOW_VALUE(flow), .BATCH_VALUE(batch),
      .TOTAL_VALUE(total), .PEAK_VALUE(peak), .BATCH_KILO_UNITS(bkilo),
      .TOTAL_KILO_UNITS(tkilo), .BATCH_ENABLED(bken), .SCALE_LOW_POINT(lo),
      .SCALE_HIGH_POINT(hi), .LOW_EXTENSION_PCT(lpct), .HIGH_EXTENSION_PCT(hpct),
      .FAULT_OUTPUT_LEVEL(flt), .RANGE_EXCEEDED(rexc), .FRAME_RECEIVED(frame),
      .BUS_LEVEL(blvl), .FRAME_GAP_TIMEOUT(gto), .OUT_LEVEL(level), .OUT_ENABLE(en),
      .OUT_CRITICAL(crit), .OUT_CLAMPED(clamped), .OUT_GAP_EXPIRED(expired));
   aos_loop_receiver rx_u (.level(level), .enable(en), .sensed(sensed));
   ////////////////////////////////////////
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask : cyc
   task automatic cmp(input logic [16:0] got, input logic [16:0] exp);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask : cmp
   // The scaler recomputes continuously, so two full passes are awaited.
   task automatic settle(input logic [16:0] exp);
      cyc(140);
      cmp(sensed, exp);
   endtask : settle
   task automatic pulse;
      frame <= 1'b1;
      cyc(1);
      frame <= 1'b0;
   endtask : pulse
   task automatic close_out;
      $display("compared %0d, mismatched %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : close_out
   ////////////////////////////////////////
   initial begin
      forever #10 clk = ~clk;
   end
   initial begin
      cyc(20000);
      mismatches++;
      close_out();
   end
   initial begin
      cyc(3);
      rst <= 1'b0;
      for (int i = 0; i < 10; i++) begin
         kind <= kt1[i];
         mode <= mt1[i];
         settle(et1[i]);
      end
      $display("test modes done");
      mode <= 3'h2;
      lo <= 32'h3E8;
      hi <= 32'h0;
      flow <= 32'hFA;
      settle(17'h3E80);
      lo <= 32'h0;
      hi <= 32'h3E8;
      mode <= 3'h1;
      flow <= 32'h7D0;
      hpct <= 10'h3FF;
      settle(17'h5DAC);
      cmp(17'(clamped), 17'h1);
      kind <= 2'h2;
      mode <= 3'h5;
      settle(17'h2AEE);
      kind <= 2'h0;
      mode <= 3'h2;
      flow <= 32'hFFFFFC18;
      lpct <= 10'h64;
      settle(17'hE10);
      $display("test clamp done");
      flow <= 32'h1F4;
      src <= 2'h1;
      bkilo <= 1'b1;
      batch <= 32'h7A120;
      settle(17'h2EE0);
      src <= 2'h2;
      total <= 32'h1F4;
      settle(17'h2EE0);
      hold <= 1'b1;
      peak <= 32'hFA;
      settle(17'h1F40);
      hold <= 1'b0;
      src <= 2'h1;
      bken <= 1'b0;
      settle(17'h5654);
      src <= 2'h0;
      bken <= 1'b1;
      $display("test sources done");
      for (int i = 0; i < 12; i++) begin
         kind <= kt2[i];
         mode <= (kt2[i] == 2'h2) ? 3'h3 : 3'h2;
         flt <= ft2[i];
         settle((kt2[i] == 2'h2) ? 17'h9C4 : 17'h2EE0);
         rexc <= 1'b1;
         cyc(3);
         cmp(sensed, et2[i]);
         cmp(17'(crit), 17'h1);
         rexc <= 1'b0;
         settle((kt2[i] == 2'h2) ? 17'h9C4 : 17'h2EE0);
      end
      $display("test faults done");
      kind <= 2'h0;
      mode <= 3'h7;
      flt <= 3'h1;
      gto <= 7'h1;
      pulse();
      cyc(4);
      cmp(sensed, 17'h1234);
      ce <= 1'b0;
      blvl <= 17'h00777;
      cyc(5);
      cmp(sensed, 17'h1234);
      ce <= 1'b1;
      repeat (6) begin
         cyc(10);
         pulse();
      end
      cmp(17'(expired), 17'h0);
      cyc(30);
      cmp(17'(expired), 17'h1);
      cmp(sensed, 17'h5654);
      pulse();
      cyc(3);
      cmp(17'(expired), 17'h0);
      gto <= 7'h0;
      rexc <= 1'b1;
      pulse();
      cyc(100);
      cmp(17'(expired), 17'h0);
      cmp(sensed, 17'h00777);
      $display("test bus done");
      close_out();
   end
endmodule : test_analog_output_scaler
